/* crypto_command_dispatch.sv */
`timescale 1ns/1ps
module crypto_command_dispatch
	import crypto_dispatch_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic         cmdValid,
	output logic              cmdReady,
	input  wire logic [4:0]   cmdType,
	input  wire logic         cmdStoreVector,
	input  wire logic [7:0]   cmdParam,
	input  wire logic [7:0]   cmdParam1,
	input  wire logic [15:0]  cmdSrcAddr,
	input  wire logic [15:0]  cmdLength,
	input  wire logic [15:0]  cmdDstAddr,
	input  wire logic [15:0]  cmdKeyAddr,
	input  wire logic [15:0]  cmdVectorAddr,
	input  wire logic [15:0]  cmdKey2Addr,
	input  wire logic [15:0]  returnAddr,
	input  wire logic         countLoad,
	input  wire logic [15:0]  countInit,
	input  wire logic         errClear,
	output logic              memReq,
	output logic              memWe,
	output logic      [15:0]  memAddr,
	output logic      [7:0]   memWdata,
	input  wire logic         memAck,
	input  wire logic [7:0]   memRdata,
	input  wire logic [4:0]   keyEntType,
	input  wire logic [7:0]   keyEntParam,
	input  wire logic [1:0]   keyEntKind,
	output logic              kernelReq,
	output logic      [4:0]   kernelType,
	output logic      [2:0]   kernelMode,
	output logic      [1:0]   kernelKeyLen,
	output logic      [6:0]   kernelRounds,
	output logic              kernelConform,
	output logic              kernelAltTerm,
	output logic      [1:0]   kernelUsage,
	output logic      [7:0]   kernelParam1,
	output logic              kernelFinal,
	output logic      [4:0]   kernelBytes,
	output logic      [127:0] kernelData,
	output logic      [127:0] kernelVector,
	output logic      [383:0] kernelKey,
	output logic      [255:0] kernelKey2,
	input  wire logic         kernelAck,
	input  wire logic [127:0] kernelResult,
	input  wire logic [127:0] kernelNextVector,
	output logic      [15:0]  cmdCount,
	output logic      [15:0]  errCount,
	output logic              errFlag,
	output logic              busy
);
	typedef enum logic [9:0] {
		S_IDLE   = 10'h001,
		S_KEY    = 10'h002,
		S_VEC    = 10'h004,
		S_KEY2   = 10'h008,
		S_LOAD   = 10'h010,
		S_RUN    = 10'h020,
		S_STORE  = 10'h040,
		S_RESULT = 10'h080,
		S_WBVEC  = 10'h100,
		S_RETURN = 10'h200
	} state_t;

	state_t        state_q, state_d;
	logic [5:0]    idx_q, idx_d;
	logic [15:0]   pos_q, pos_d;
	logic [4:0]    typ_q, typ_d;
	logic [7:0]    par_q, par_d, par1_q, par1_d;
	logic          storeVec_q, storeVec_d, fail_q, fail_d;
	logic [15:0]   src_q, src_d, len_q, len_d, dst_q, dst_d;
	logic [15:0]   key_q, key_d, vec_q, vec_d, key2_q, key2_d;
	logic [383:0]  keyBuf_q, keyBuf_d;
	logic [255:0]  key2Buf_q, key2Buf_d;
	logic [127:0]  vecBuf_q, vecBuf_d, dataBuf_q, dataBuf_d;
	logic [15:0]   cmdCount_q, cmdCount_d, errCount_q, errCount_d;
	logic          errFlag_q, errFlag_d;
	logic [5:0]    need;
	logic [15:0]   base, remain;
	logic [7:0]    wbyte;
	logic [1:0]    wantKind;
	logic          fetch, xferBusy, entryOk, keyHit, lastWord, doStore, finish;
	logic [4:0]    word, chunk, ctrSpan;
	logic [3:0]    ctrLast;
	logic          isCtr, isAes, isTdes, isM2, isC2, isMac, crcClear, crcStep;
	logic [63:0]   crcVal, resWord, retWord;
	logic [127:0]  ctrNext;

	// ------------------------------------------------------------
	// Command decoding
	// ------------------------------------------------------------
	function automatic logic [5:0] keyBytes(input logic [4:0] t, input logic [7:0] p);
		case (t[4:1])
			TY_CRC[4:1], TY_M2[4:1]: keyBytes = NB_8;
			TY_AES[4:1]: case (p[KLEN_LSB +: 2])
				KLEN_1:  keyBytes = NB_24;
				KLEN_2:  keyBytes = NB_32;
				default: keyBytes = NB_16;
			endcase
			TY_TDES[4:1]: case (p[KLEN_LSB +: 2])
				KLEN_1:  keyBytes = NB_24;
				KLEN_2:  keyBytes = NB_16;
				default: keyBytes = NB_8;
			endcase
			TY_MAC[4:1]: keyBytes = NB_48;
			TY_C2[4:1]:  keyBytes = NB_0;
			default:     keyBytes = (t == TY_CSA2) ? NB_8 : NB_16;
		endcase
		if (t == TY_COPY) keyBytes = NB_0;
	endfunction : keyBytes

	function automatic logic [5:0] vecBytes(input logic [4:0] t, input logic [7:0] p);
		case (t[4:1])
			TY_M2[4:1], TY_TDES[4:1]: vecBytes = NB_8;
			TY_AES[4:1]: vecBytes = NB_16;
			TY_C2[4:1]:  vecBytes = NB_7;
			TY_MAC[4:1]: vecBytes = p[0] ? NB_8 : NB_0;
			default:     vecBytes = NB_0;
		endcase
	endfunction : vecBytes

	// Entry control match: inverse and forward codes count as one family
	function automatic logic sameKind(input logic [4:0] t, input logic [4:0] e);
		if (t >= TY_PAIR_LO && t <= TY_PAIR_HI) sameKind = (t[4:1] == e[4:1]);
		else sameKind = (t == e);
	endfunction : sameKind

	function automatic logic [7:0] paramMask(input logic [4:0] t);
		case (t[4:1])
			TY_COPY[4:1]: paramMask = (t == TY_CRC) ? PMASK_CRC : 8'h00;
			TY_TDES[4:1]: paramMask = PMASK_TDES;
			TY_C2[4:1], TY_MAC[4:1]: paramMask = PMASK_BIT0;
			default: paramMask = (t == TY_CSA2) ? PMASK_BIT0 : PMASK_ALL;
		endcase
	endfunction : paramMask

	always_comb begin
		isAes  = (typ_q[4:1] == TY_AES[4:1]);
		isTdes = (typ_q[4:1] == TY_TDES[4:1]);
		isM2   = (typ_q[4:1] == TY_M2[4:1]);
		isC2   = (typ_q[4:1] == TY_C2[4:1]);
		isMac  = (typ_q[4:1] == TY_MAC[4:1]);
		word   = isAes ? W_AES : ((typ_q == TY_COPY || typ_q == TY_CRC) ? W_BYTE : W_SMALL);
		remain = len_q - pos_q;
		chunk  = (remain < {11'h000, word}) ? remain[4:0] : word;
		lastWord = (remain <= {11'h000, chunk});
		// Forward MAC keeps only its state; inverse stores the regenerated tail
		doStore = !(typ_q == TY_MAC) && !(typ_q == TY_MAC_INV && !lastWord);
		isCtr   = 1'b0;
		ctrSpan = CTR_NARROW;
		ctrLast = isAes ? LAST_AES : LAST_SMALL;
		if ((isM2 || isTdes) && par_q[MODE_LSB +: 3] == MODE_CTR) isCtr = 1'b1;
		if (isAes) begin
			case (par_q[MODE_LSB +: 3])
				MODE_CTR:  isCtr = 1'b1;
				MODE_WIDE: begin isCtr = 1'b1; ctrSpan = CTR_WIDE; end
				MODE_FULL: begin isCtr = 1'b1; ctrSpan = CTR_FULL; end
				default:   isCtr = 1'b0;
			endcase
		end
		resWord = (typ_q == TY_CRC) ? crcVal : vecBuf_q[63:0];
		retWord = {errFlag_q, 15'h0000, errCount_q, 16'h0000, cmdCount_q};
	end

	// ------------------------------------------------------------
	// Byte transfer engine
	// ------------------------------------------------------------
	always_comb begin
		need     = NB_0;
		base     = 16'h0000;
		wbyte    = 8'h00;
		wantKind = KIND_KEY;
		fetch    = 1'b0;
		case (state_q)
			S_KEY:  begin need = keyBytes(typ_q, par_q); base = key_q; fetch = 1'b1; end
			S_VEC:  begin
				need = vecBytes(typ_q, par_q); base = vec_q; fetch = 1'b1; wantKind = KIND_VEC;
			end
			S_KEY2: begin
				need = isM2 ? NB_32 : NB_0; base = key2_q; fetch = 1'b1; wantKind = KIND_KEY2;
			end
			S_LOAD: begin need = {1'b0, chunk}; base = src_q + pos_q; end
			S_STORE: begin
				need = {1'b0, chunk}; base = dst_q + pos_q;
				wbyte = dataBuf_q[{idx_q[3:0], 3'b000} +: 8];
			end
			S_RESULT: begin
				need = (typ_q == TY_CRC) ? 6'(4'h1 << par_q[1:0]) : ((typ_q == TY_MAC) ? NB_8 : NB_0);
				base = dst_q;
				wbyte = resWord[{idx_q[2:0], 3'b000} +: 8];
			end
			S_WBVEC: begin
				if (!storeVec_q) need = NB_0;
				else if (typ_q == TY_CRC) need = 6'(4'h1 << par_q[1:0]);
				else if (isMac) need = NB_8;
				else if (isC2) need = par_q[0] ? NB_7 : NB_0;
				else if (isAes || isTdes || isM2) need = vecBytes(typ_q, par_q);
				else need = NB_0;
				base = vec_q;
				wbyte = (typ_q == TY_CRC) ? resWord[{idx_q[2:0], 3'b000} +: 8]
				                          : vecBuf_q[{idx_q[3:0], 3'b000} +: 8];
			end
			S_RETURN: begin need = RET_BYTES; base = returnAddr; wbyte = retWord[{idx_q[2:0], 3'b000} +: 8]; end
			default: need = NB_0;
		endcase
		xferBusy = (idx_q < need);
		memReq   = xferBusy;
		memWe    = (state_q == S_STORE) || (state_q == S_RESULT) || (state_q == S_WBVEC)
		        || (state_q == S_RETURN);
		memAddr  = base + {10'h000, idx_q};
		memWdata = wbyte;
		entryOk  = sameKind(typ_q, keyEntType) && keyEntKind == wantKind
		        && ((par_q ^ keyEntParam) & paramMask(typ_q)) == 8'h00;
		keyHit   = fetch && xferBusy && memAck && memAddr[TABLE_BIT] && !entryOk;
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q; idx_d = idx_q; pos_d = pos_q; typ_d = typ_q; par_d = par_q;
		par1_d = par1_q; storeVec_d = storeVec_q; fail_d = fail_q; src_d = src_q;
		len_d = len_q; dst_d = dst_q; key_d = key_q; vec_d = vec_q; key2_d = key2_q;
		keyBuf_d = keyBuf_q; key2Buf_d = key2Buf_q; vecBuf_d = vecBuf_q; dataBuf_d = dataBuf_q;
		cmdCount_d = countLoad ? countInit : cmdCount_q;
		errCount_d = errCount_q;
		errFlag_d  = errFlag_q & ~errClear;
		cmdReady   = (state_q == S_IDLE);
		kernelReq  = (state_q == S_RUN);
		crcClear = 1'b0; crcStep = 1'b0; finish = 1'b0;
		if (memAck && xferBusy) idx_d = idx_q + 6'h01;
		case (state_q)
			S_IDLE: if (cmdValid) begin
				typ_d = cmdType; par_d = cmdParam; par1_d = cmdParam1;
				storeVec_d = cmdStoreVector; src_d = cmdSrcAddr; len_d = cmdLength;
				dst_d = cmdDstAddr; key_d = cmdKeyAddr; vec_d = cmdVectorAddr;
				key2_d = cmdKey2Addr; vecBuf_d = '0; crcClear = 1'b1;
				fail_d = 1'b0; idx_d = NB_0; pos_d = 16'h0000; state_d = S_KEY;
			end
			S_KEY, S_VEC, S_KEY2: begin
				if (keyHit) begin
					fail_d = 1'b1; finish = 1'b1;
				end else if (memAck && xferBusy) begin
					if (state_q == S_KEY) keyBuf_d[{idx_q, 3'b000} +: 8] = memRdata;
					else if (state_q == S_VEC) vecBuf_d[{idx_q[3:0], 3'b000} +: 8] = memRdata;
					else key2Buf_d[{idx_q[4:0], 3'b000} +: 8] = memRdata;
				end else if (!xferBusy) begin
					idx_d = NB_0;
					if (state_q == S_KEY) state_d = S_VEC;
					else if (state_q == S_VEC) state_d = S_KEY2;
					else if (len_q == 16'h0000) finish = 1'b1;
					else state_d = S_LOAD;
				end
			end
			S_LOAD: begin
				if (memAck && xferBusy) begin
					dataBuf_d[{idx_q[3:0], 3'b000} +: 8] = memRdata;
					crcStep = (typ_q == TY_CRC);
				end else if (!xferBusy) begin
					idx_d = NB_0;
					if (typ_q == TY_COPY) state_d = S_STORE;
					else if (typ_q != TY_CRC) state_d = S_RUN;
					else begin
						pos_d = pos_q + {11'h000, chunk};
						state_d = lastWord ? S_RESULT : S_LOAD;
					end
				end
			end
			S_RUN: if (kernelAck) begin
				dataBuf_d = kernelResult;
				vecBuf_d  = isCtr ? ctrNext : kernelNextVector;
				if (doStore) state_d = S_STORE;
				else begin
					pos_d = pos_q + {11'h000, chunk};
					state_d = lastWord ? S_RESULT : S_LOAD;
				end
			end
			S_STORE: if (!xferBusy) begin
				idx_d = NB_0;
				pos_d = pos_q + {11'h000, chunk};
				state_d = lastWord ? S_RESULT : S_LOAD;
			end
			S_RESULT: if (!xferBusy) begin idx_d = NB_0; state_d = S_WBVEC; end
			S_WBVEC:  if (!xferBusy) finish = 1'b1;
			S_RETURN: if (!xferBusy) begin idx_d = NB_0; state_d = S_IDLE; end
			default: state_d = S_IDLE;
		endcase
		// Count and flag settle before the return word goes out
		if (finish) begin
			state_d    = S_RETURN;
			idx_d      = NB_0;
			cmdCount_d = cmdCount_q + 16'h0001;
			if (fail_d) begin
				errCount_d = cmdCount_q + 16'h0001;
				errFlag_d  = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_IDLE; idx_q <= NB_0; pos_q <= 16'h0000; typ_q <= TY_COPY;
			par_q <= 8'h00; par1_q <= 8'h00; storeVec_q <= 1'b0; fail_q <= 1'b0;
			src_q <= 16'h0000; len_q <= 16'h0000; dst_q <= 16'h0000; key_q <= 16'h0000;
			vec_q <= 16'h0000; key2_q <= 16'h0000; keyBuf_q <= '0; key2Buf_q <= '0;
			vecBuf_q <= '0; dataBuf_q <= '0; cmdCount_q <= 16'h0000;
			errCount_q <= 16'h0000; errFlag_q <= 1'b0;
		end else begin
			state_q <= state_d; idx_q <= idx_d; pos_q <= pos_d; typ_q <= typ_d;
			par_q <= par_d; par1_q <= par1_d; storeVec_q <= storeVec_d; fail_q <= fail_d;
			src_q <= src_d; len_q <= len_d; dst_q <= dst_d; key_q <= key_d;
			vec_q <= vec_d; key2_q <= key2_d; keyBuf_q <= keyBuf_d; key2Buf_q <= key2Buf_d;
			vecBuf_q <= vecBuf_d; dataBuf_q <= dataBuf_d; cmdCount_q <= cmdCount_d;
			errCount_q <= errCount_d; errFlag_q <= errFlag_d;
		end
	end

	// ------------------------------------------------------------
	// Processing units and kernel side
	// ------------------------------------------------------------
	crc_unit u_crc (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clear   (crcClear),
		.step    (crcStep),
		.dataIn  (memRdata),
		.poly    (keyBuf_q[63:0]),
		.size    (par_q[1:0]),
		.crc     (crcVal)
	);

	counter_step u_ctr (
		.vecIn   (vecBuf_q),
		.lastIdx (ctrLast),
		.span    (ctrSpan),
		.vecOut  (ctrNext)
	);

	assign kernelType    = typ_q;
	assign kernelMode    = isC2 ? {2'b00, par_q[0]} : par_q[MODE_LSB +: 3];
	assign kernelKeyLen  = par_q[KLEN_LSB +: 2];
	assign kernelRounds  = (par_q[ROUND_LSB +: 5] == 5'h00) ? ROUNDS_ZERO
	                     : {par_q[ROUND_LSB +: 5], 2'b00};
	assign kernelConform = (typ_q == TY_CSA2) && par_q[0];
	assign kernelAltTerm = isAes && par_q[ALT_BIT];
	assign kernelUsage   = (isAes || isTdes) ? par_q[USAGE_LSB +: 2] : 2'b00;
	assign kernelParam1  = par1_q;
	assign kernelFinal   = lastWord;
	assign kernelBytes   = chunk;
	assign kernelData    = dataBuf_q;
	assign kernelVector  = vecBuf_q;
	assign kernelKey     = keyBuf_q;
	assign kernelKey2    = key2Buf_q;
	assign cmdCount      = cmdCount_q;
	assign errCount      = errCount_q;
	assign errFlag       = errFlag_q;
	assign busy          = (state_q != S_IDLE);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	property p_take;
		cmdValid && cmdReady |=> state_q == S_KEY && typ_q == $past(cmdType);
	endproperty
	a_take: assert property (p_take) else $error("command not taken");
	property p_serial;
		state_q != S_IDLE |=> typ_q == $past(typ_q) && len_q == $past(len_q);
	endproperty
	a_serial: assert property (p_serial) else $error("pop while busy");
	property p_count;
		(state_q != S_RETURN) ##1 (state_q == S_RETURN) |-> cmdCount_q == $past(cmdCount_q) + 16'h0001;
	endproperty
	a_count: assert property (p_count) else $error("count not advanced");
	property p_sticky;
		errFlag_q && !errClear |=> errFlag_q;
	endproperty
	a_sticky: assert property (p_sticky) else $error("error flag lost");
	property p_reject;
		keyHit |=> state_q == S_RETURN && errFlag_q && errCount_q == cmdCount_q;
	endproperty
	a_reject: assert property (p_reject) else $error("mismatch not skipped");
	property p_hold;
		kernelReq && !kernelAck |=> kernelReq;
	endproperty
	a_hold: assert property (p_hold) else $error("kernel request dropped");
	property p_wb_flag;
		state_q == S_WBVEC && memReq |-> storeVec_q && memAddr == vec_q + {10'h000, idx_q};
	endproperty
	a_wb_flag: assert property (p_wb_flag) else $error("vector write without flag");
	property p_rounds;
		par_q[ROUND_LSB +: 5] == 5'h00 |-> kernelRounds == ROUNDS_ZERO;
	endproperty
	a_rounds: assert property (p_rounds) else $error("round zero not 32");
	property p_nonce;
		kernelReq && kernelAck && isM2 && isCtr |=> vecBuf_q[31:0] == $past(vecBuf_q[31:0]);
	endproperty
	a_nonce: assert property (p_nonce) else $error("nonce changed");

	c_copy:  cover property (state_q == S_STORE && typ_q == TY_COPY ##1 state_q == S_RESULT);
	c_error: cover property (keyHit);
	c_ctr:   cover property (kernelAck && isCtr && isAes);
endmodule : crypto_command_dispatch

/* crypto_dispatch_pkg.sv */
// Overview of operation
// - Nonempty queue: pop, decode, start one block
// - Block fetches inputs, processes, writes local memory
// - Copy moves length bytes source to destination
// - CRC polynomial lacks top coefficient; hardware adds one
// - CRC to destination, to vector if flagged
// - CRC size code selects 8/16/32/64 bits
// - Descrambler conformance active only when bit set
// - Cipher data key 64 bits, system key 256
// - Counter mode: last four vector bytes count
// - Three-bit mode field: block, chain, feedback, counter
// - Round field times four, zero means 32
// - AES modes zero to six, three key sizes
// - AES counter spans four, eight or sixteen bytes
// - Two-bit usage field for AES and TDES
// - TDES counter mode: last four bytes per word
// - TDES key sizes: single, triple, two-key triple
// - C2 key from vector, rewritten in chaining mode
// - C2 length multiple of eight, one mode bit
// - MAC state loaded or zero, result written out
// - Inverse MAC regenerates final eight content bytes
// - MAC key is 48 bytes from key pointer
// - Five-bit command type, paired adjacent inverse codes
// - Return word: count, error count, sticky flag
// - Key table mismatch skips command, sets flag
package crypto_dispatch_pkg;
	// ------------------------------------------------------------
	// Command type codes
	// ------------------------------------------------------------
	localparam logic [4:0] TY_COPY    = 5'h00;
	localparam logic [4:0] TY_CRC     = 5'h01;
	localparam logic [4:0] TY_CSA2    = 5'h02;
	localparam logic [4:0] TY_CSA3    = 5'h03;
	localparam logic [4:0] TY_AES     = 5'h04;
	localparam logic [4:0] TY_TDES    = 5'h06;
	localparam logic [4:0] TY_C2      = 5'h08;
	localparam logic [4:0] TY_MAC     = 5'h0a;
	localparam logic [4:0] TY_MAC_INV = 5'h0b;
	localparam logic [4:0] TY_M2      = 5'h0c;
	localparam logic [4:0] TY_PAIR_LO = 5'h04;
	localparam logic [4:0] TY_PAIR_HI = 5'h0d;
	// ------------------------------------------------------------
	// Parameter field layout and codes
	// ------------------------------------------------------------
	localparam int         MODE_LSB   = 0;
	localparam int         KLEN_LSB   = 3;
	localparam int         ALT_BIT    = 5;
	localparam int         USAGE_LSB  = 6;
	localparam int         ROUND_LSB  = 3;
	localparam logic [2:0] MODE_CTR   = 3'h3;
	localparam logic [2:0] MODE_WIDE  = 3'h5;
	localparam logic [2:0] MODE_FULL  = 3'h6;
	localparam logic [1:0] KLEN_1     = 2'h1;
	localparam logic [1:0] KLEN_2     = 2'h2;
	localparam logic [6:0] ROUNDS_ZERO = 7'h20;
	localparam logic [7:0] PMASK_CRC  = 8'h03;
	localparam logic [7:0] PMASK_BIT0 = 8'h01;
	localparam logic [7:0] PMASK_TDES = 8'hdf;
	localparam logic [7:0] PMASK_ALL  = 8'hff;
	// ------------------------------------------------------------
	// Key table data kinds and address split
	// ------------------------------------------------------------
	localparam logic [1:0] KIND_KEY   = 2'h0;
	localparam logic [1:0] KIND_VEC   = 2'h1;
	localparam logic [1:0] KIND_KEY2  = 2'h2;
	localparam int         TABLE_BIT  = 15;
	// ------------------------------------------------------------
	// Byte counts
	// ------------------------------------------------------------
	localparam logic [5:0] NB_0       = 6'h00;
	localparam logic [5:0] NB_7       = 6'h07;
	localparam logic [5:0] NB_8       = 6'h08;
	localparam logic [5:0] NB_16      = 6'h10;
	localparam logic [5:0] NB_24      = 6'h18;
	localparam logic [5:0] NB_32      = 6'h20;
	localparam logic [5:0] NB_48      = 6'h30;
	localparam logic [5:0] RET_BYTES  = 6'h08;
	localparam logic [4:0] W_BYTE     = 5'h01;
	localparam logic [4:0] W_SMALL    = 5'h08;
	localparam logic [4:0] W_AES      = 5'h10;
	localparam logic [4:0] CTR_NARROW = 5'h04;
	localparam logic [4:0] CTR_WIDE   = 5'h08;
	localparam logic [4:0] CTR_FULL   = 5'h10;
	localparam logic [3:0] LAST_SMALL = 4'h7;
	localparam logic [3:0] LAST_AES   = 4'hf;
endpackage : crypto_dispatch_pkg

/* crc_unit.sv */
`timescale 1ns/1ps
module crc_unit
	import crypto_dispatch_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clear,
	input  wire logic        step,
	input  wire logic [7:0]  dataIn,
	input  wire logic [63:0] poly,
	input  wire logic [1:0]  size,
	output logic      [63:0] crc
);
	logic [63:0] crc_q;
	logic [63:0] crc_d;
	logic [63:0] mask;
	logic [63:0] nxt;
	logic [5:0]  top;
	logic        fb;

	always_comb begin
		top  = 6'(8 << size) - 6'h01;
		mask = {64{1'b1}} >> (6'h3f - top);
		nxt  = crc_q;
		fb   = 1'b0;
		for (int b = 7; b >= 0; b--) begin
			// Shifted-out bit stands for the implied top coefficient
			fb  = nxt[top] ^ dataIn[b];
			nxt = ((nxt << 1) ^ (fb ? poly : 64'h0000)) & mask;
		end
		crc_d = clear ? 64'h0000 : (step ? nxt : crc_q);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) crc_q <= 64'h0000;
		else        crc_q <= crc_d;
	end

	assign crc = crc_q;

	property p_crc_width;
		@(posedge ref_clk) disable iff (!rst_n)
		step |=> (crc_q & ~$past(mask)) == 64'h0000;
	endproperty
	a_crc_width: assert property (p_crc_width) else $error("crc exceeds size");
endmodule : crc_unit

/* counter_step.sv */
`timescale 1ns/1ps
module counter_step
	import crypto_dispatch_pkg::*;
(
	input  wire logic [127:0] vecIn,
	input  wire logic [3:0]   lastIdx,
	input  wire logic [4:0]   span,
	output logic      [127:0] vecOut
);
	logic       carry;
	logic [8:0] sum;

	// Big-endian count over bytes lastIdx-span+1..lastIdx; others untouched
	always_comb begin
		carry  = 1'b1;
		sum    = 9'h000;
		vecOut = vecIn;
		for (int i = 15; i >= 0; i--) begin
			if (i <= int'(lastIdx) && i > int'(lastIdx) - int'(span)) begin
				sum = {1'b0, vecIn[i*8 +: 8]} + {8'h00, carry};
				vecOut[i*8 +: 8] = sum[7:0];
				carry = sum[8];
			end
		end
	end
endmodule : counter_step

/* crypto_far_model.sv */
`timescale 1ns/1ps
module crypto_far_model (
	input  wire logic         ref_clk,
	input  wire logic         memReq,
	input  wire logic         memWe,
	input  wire logic [15:0]  memAddr,
	input  wire logic [7:0]   memWdata,
	output logic              memAck,
	output logic      [7:0]   memRdata,
	input  wire logic         kernelReq,
	input  wire logic [127:0] kernelData,
	output logic              kernelAck,
	output logic      [127:0] kernelResult
);
	logic [7:0] mem [0:65535];
	initial begin
		memAck = 1'b0;
		kernelAck = 1'b0;
	end
	// Every request waits one cycle before its acknowledge
	always @(posedge ref_clk) begin
		memAck <= memReq & !memAck;
		kernelAck <= kernelReq & !kernelAck;
		if (memReq & memAck & memWe) mem[memAddr] <= memWdata;
	end
	// Outside an acknowledge the lines carry garbage
	assign memRdata = memAck ? mem[memAddr] : ~mem[memAddr];
	assign kernelResult = kernelAck ? kernelData : ~kernelData;
endmodule : crypto_far_model

/* crypto_command_dispatch_bench.sv */
`timescale 1ns/1ps
module crypto_command_dispatch_bench;
	import crypto_dispatch_pkg::*;
	logic         ref_clk = 0, rst_n = 0, cmdValid = 0, cmdStoreVector = 0;
	logic         countLoad = 0, errClear = 0, cmdReady, memReq, memWe, memAck;
	logic         kernelReq, kernelConform, kernelAltTerm, kernelFinal, kernelAck;
	logic         errFlag, busy;
	logic [4:0]   cmdType = 0, keyEntType = 0, kernelType, kernelBytes;
	logic [7:0]   cmdParam = 0, cmdParam1 = 0, keyEntParam = 0, memWdata, memRdata;
	logic [1:0]   keyEntKind = 0, kernelKeyLen, kernelUsage;
	logic [15:0]  cmdSrcAddr = 16'h0010, cmdLength = 16'h0002, cmdDstAddr = 16'h0020;
	logic [15:0]  cmdKeyAddr = 0, cmdVectorAddr = 0, cmdKey2Addr = 0, countInit = 16'hffff;
	logic [15:0]  returnAddr = 16'h0100, memAddr, cmdCount, errCount;
	logic [2:0]   kernelMode;
	logic [6:0]   kernelRounds;
	logic [7:0]   kernelParam1;
	logic [127:0] kernelData, kernelVector, kernelResult;
	logic [383:0] kernelKey;
	logic [255:0] kernelKey2;
	int           nErrors = 0, checks = 0, cycles = 0;
	always #4 ref_clk = ~ref_clk;
	crypto_command_dispatch dut (.ref_clk, .rst_n, .cmdValid, .cmdReady, .cmdType,
		.cmdStoreVector, .cmdParam, .cmdParam1, .cmdSrcAddr, .cmdLength, .cmdDstAddr,
		.cmdKeyAddr, .cmdVectorAddr, .cmdKey2Addr, .returnAddr, .countLoad, .countInit,
		.errClear, .memReq, .memWe, .memAddr, .memWdata, .memAck, .memRdata, .keyEntType,
		.keyEntParam, .keyEntKind, .kernelReq, .kernelType, .kernelMode, .kernelKeyLen,
		.kernelRounds, .kernelConform, .kernelAltTerm, .kernelUsage, .kernelParam1,
		.kernelFinal, .kernelBytes, .kernelData, .kernelVector, .kernelKey, .kernelKey2,
		.kernelAck, .kernelResult, .kernelNextVector(kernelResult), .cmdCount, .errCount,
		.errFlag, .busy);
	crypto_far_model mdl (.ref_clk, .memReq, .memWe, .memAddr, .memWdata, .memAck,
		.memRdata, .kernelReq, .kernelData, .kernelAck, .kernelResult);
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task conclude;
		if (nErrors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			nErrors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task run(input logic [4:0] ty, input logic [15:0] key);
		@(negedge ref_clk);
		cmdType = ty;
		cmdKeyAddr = key;
		cmdValid = 1;
		@(negedge ref_clk);
		chk({busy, cmdReady}, 16'h0002, "busy");
		repeat (400) if (busy === 1'b1) @(negedge ref_clk);
		cmdValid = 0;
		chk(busy, 16'h0000, "done");
	endtask : run
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task copy_case(input logic [15:0] expCount, input logic expFlag);
		mdl.mem[16'h0020] = 8'h00;
		mdl.mem[16'h0021] = 8'h00;
		run(TY_COPY, 16'h0000);
		chk({mdl.mem[16'h0021], mdl.mem[16'h0020]}, 16'h3ca5, "copy");
		chk({mdl.mem[16'h0101], mdl.mem[16'h0100]}, expCount, "count");
		chk({mdl.mem[16'h0107][7], errFlag}, {14'h0000, expFlag, expFlag}, "flag");
	endtask : copy_case
	task mismatch_case;
		keyEntType = TY_COPY;
		run(TY_AES, 16'h8000);
		chk({mdl.mem[16'h0105], mdl.mem[16'h0104]}, 16'h0002, "errcnt");
		chk({mdl.mem[16'h0107], 7'h00, errFlag}, 16'h8001, "errflag");
		chk(cmdCount, 16'h0002, "cmdcnt");
		chk(errCount, 16'h0002, "errout");
	endtask : mismatch_case
	task ctr_case(input logic [4:0] ty, input logic [7:0] par, input logic [15:0] vecAt,
		input logic [6:0] rounds, input logic [15:0] exp);
		cmdParam = par;
		cmdVectorAddr = vecAt;
		cmdStoreVector = 1;
		cmdLength = (ty == TY_AES) ? 16'h0010 : 16'h0008;
		mdl.mem[16'h0020] = 8'h00;
		mdl.mem[16'h003b] = 8'h00;
		for (int i = 0; i < 4; i++) mdl.mem[16'h003c + i] = 8'hff;
		run(ty, 16'h0040);
		chk({mdl.mem[16'h003b], mdl.mem[16'h003f]}, exp, "counter");
		chk({mdl.mem[16'h0021], mdl.mem[16'h0020]}, 16'h3ca5, "data");
		chk({kernelType, kernelMode, kernelUsage}, {6'h00, ty, par[2:0], par[7:6]},
			"fields");
		chk(kernelRounds, {9'h000, rounds}, "rounds");
	endtask : ctr_case
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			conclude();
		end
	end
	initial begin
		mdl.mem[16'h0010] = 8'ha5;
		mdl.mem[16'h0011] = 8'h3c;
		repeat (16) @(negedge ref_clk);
		rst_n = 1;
		copy_case(16'h0001, 1'b0);
		mismatch_case();
		copy_case(16'h0003, 1'b1);
		@(negedge ref_clk);
		errClear = 1;
		countLoad = 1;
		@(negedge ref_clk);
		errClear = 0;
		countLoad = 0;
		copy_case(16'h0000, 1'b0);
		ctr_case(TY_M2, 8'h03, 16'h0038, 7'h20, 16'h0000);
		ctr_case(TY_AES, 8'h03, 16'h0030, 7'h20, 16'h0000);
		ctr_case(TY_AES, 8'h85, 16'h0030, 7'h40, 16'h0100);
		conclude();
	end
endmodule : crypto_command_dispatch_bench
